/* File: design/edge_sense.sv */
// per-bit edge detector with selectable polarity
`timescale 1ns/1ps
`default_nettype none
module edge_sense #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   // pins and polarity (1 = falling)
   input  wire logic [W-1:0] din_i,
   input  wire logic [W-1:0] fall_i,
   // one-cycle edge pulses
   output logic      [W-1:0] edge_o
);
   logic [W-1:0] prev_reg;
   logic         armed_reg;

   // first cycle after reset is ignored so a pin already high is no edge
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         armed_reg <= 1'b0;
      end else begin
         armed_reg <= 1'b1;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               prev_reg[i] <= 1'b0;
            end else begin
               prev_reg[i] <= din_i[i];
            end
         end
         // rising when fall_i is 0, falling when 1
         assign edge_o[i] = armed_reg & (fall_i[i] ? (prev_reg[i] & ~din_i[i])
                                                   : (~prev_reg[i] & din_i[i]));
      end
   endgenerate
endmodule
`default_nettype wire

/* File: design/vic_top.sv */
// vectored interrupt controller, free-running timer and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module vic_top (
   // clock and reset
   input  wire logic                          mclk_i,
   input  wire logic                          rst_i,
   // AHB-Lite slave
   input  wire logic                          hsel_i,
   input  wire logic [31:0]                   haddr_i,
   input  wire logic [1:0]                    htrans_i,
   input  wire logic                          hwrite_i,
   input  wire logic [2:0]                    hsize_i,
   input  wire logic                          hready_i,
   input  wire logic [31:0]                   hwdata_i,
   output logic      [31:0]                   hrdata_o,
   output logic                               hreadyout_o,
   output logic                               hresp_o,
   // event sources
   input  wire logic [vic_pkg::NUM_EP-1:0]    ep_event_i,
   input  wire logic                          hub_event_i,
   input  wire logic                          i2c_event_i,
   input  wire logic [vic_pkg::SINK_W-1:0]    sink_pin_i,
   input  wire logic [vic_pkg::GPIO_W-1:0]    gpio_pin_i,
   // vector handshake with the core
   output logic                               vec_req_o,
   output logic      [vic_pkg::VEC_W-1:0]     vec_num_o,
   input  wire logic                          vec_ack_i,
   // interrupt and boot
   output logic                               irq_o,
   output logic                               cpu_reset_o,
   output logic      [vic_pkg::BOOT_W-1:0]    boot_addr_o
);
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b01,
      ST_PRESENT = 2'b10
   } vec_state_type;

   // lowest set index wins; index 0 is the highest priority
   function automatic logic [vic_pkg::VEC_W-1:0] first_set(
      input logic [vic_pkg::NUM_SRC-1:0] v);
      logic [vic_pkg::VEC_W-1:0] r;
      r = '0;
      for (int k = vic_pkg::NUM_SRC - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = k[vic_pkg::VEC_W-1:0];
         end
      end
      return r;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   logic [vic_pkg::NUM_SRC-1:0]  src_en_reg;
   logic [vic_pkg::NUM_SRC-1:0]  pend_reg;
   logic [vic_pkg::NUM_SRC-1:0]  stat_reg;
   logic [vic_pkg::NUM_SRC-1:0]  mask_reg;
   logic [vic_pkg::SINK_W-1:0]   sink_ie_reg;
   logic [vic_pkg::SINK_W-1:0]   sink_pol_reg;
   logic [vic_pkg::GPIO_W-1:0]   gpio_ie_reg;
   logic [vic_pkg::NUM_PORT-1:0] gpio_pol_reg;
   logic [vic_pkg::PRE_W-1:0]    pre_reg;
   logic [vic_pkg::TMR_W-1:0]    cnt_reg;
   logic [vic_pkg::TMR_W-1:0]    cnt_next;
   logic [vic_pkg::TMR_HI_W-1:0] hi_hold_reg;
   logic                         tick;
   logic [vic_pkg::NUM_SRC-1:0]  src_ev;
   logic [vic_pkg::NUM_SRC-1:0]  live;
   logic [vic_pkg::NUM_SRC-1:0]  ack_clr;
   logic [vic_pkg::SINK_W-1:0]   sink_edge;
   logic [vic_pkg::GPIO_W-1:0]   gpio_edge;
   logic [vic_pkg::GPIO_W-1:0]   gpio_fall;
   vec_state_type                state_reg;
   logic [vic_pkg::VEC_W-1:0]    vec_num_reg;
   logic                         boot_hold_reg;
   logic                         rd_go;
   logic                         wr_go;
   logic                         wr_pend_reg;
   logic [7:0]                   wr_addr_reg;
   logic [31:0]                  rdata_reg;
   logic [7:0]                   a8;

   // ---------------- free-running timer ----------------
   always_ff @(posedge mclk_i) begin
      if (rst_i || tick) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + 7'h01;
      end
   end
   assign tick = pre_reg == vic_pkg::PRE_W'(vic_pkg::TICK_CYCLES - 1);

   assign cnt_next = cnt_reg + 12'h001;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (tick) begin
         cnt_reg <= cnt_next;
      end
   end

   // ---------------- pin edge sensing ----------------
   genvar p;
   generate
      for (p = 0; p < vic_pkg::NUM_PORT; p++) begin : g_port
         assign gpio_fall[p*vic_pkg::PORT_W +: vic_pkg::PORT_W] =
            {vic_pkg::PORT_W{gpio_pol_reg[p]}};
      end
   endgenerate

   edge_sense #(.W(vic_pkg::SINK_W)) u_sink_edge (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .din_i  (sink_pin_i),
      .fall_i (sink_pol_reg),
      .edge_o (sink_edge)
   );

   edge_sense #(.W(vic_pkg::GPIO_W)) u_gpio_edge (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .din_i  (gpio_pin_i),
      .fall_i (gpio_fall),
      .edge_o (gpio_edge)
   );

   // ---------------- source events ----------------
   always_comb begin
      src_ev = '0;
      src_ev[vic_pkg::SRC_T128]  = tick & ~cnt_reg[vic_pkg::TMR_BIT_A]
                                        & cnt_next[vic_pkg::TMR_BIT_A];
      src_ev[vic_pkg::SRC_T1024] = tick & ~cnt_reg[vic_pkg::TMR_BIT_B]
                                        & cnt_next[vic_pkg::TMR_BIT_B];
      src_ev[vic_pkg::SRC_EP0 +: vic_pkg::NUM_EP] = ep_event_i;
      src_ev[vic_pkg::SRC_HUB]  = hub_event_i;
      src_ev[vic_pkg::SRC_SINK] = |(sink_edge & sink_ie_reg);
      src_ev[vic_pkg::SRC_GPIO] = |(gpio_edge & gpio_ie_reg);
      src_ev[vic_pkg::SRC_I2C]  = i2c_event_i;
   end

   // ---------------- pending and vector delivery ----------------
   assign live = pend_reg & src_en_reg;

   always_comb begin
      ack_clr = '0;
      if (state_reg == ST_PRESENT && vec_ack_i) begin
         ack_clr[vec_num_reg] = 1'b1;
      end
   end

   // a new event in the acceptance cycle stays pending: set wins
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~ack_clr) | (src_ev & src_en_reg);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_reg   <= ST_IDLE;
         vec_num_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (|live) begin
                  state_reg   <= ST_PRESENT;
                  vec_num_reg <= first_set(live);
               end
            end
            ST_PRESENT: begin
               // withdrawn if software disables the source meanwhile
               if (vec_ack_i || !live[vec_num_reg]) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   assign vec_req_o = (state_reg == ST_PRESENT) && live[vec_num_reg];
   assign vec_num_o = vec_num_reg;

   // ---------------- sticky status and interrupt ----------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         stat_reg <= '0;
      end else if (rd_go && hit(a8, vic_pkg::OFS_STAT)) begin
         stat_reg <= src_ev;
      end else begin
         stat_reg <= stat_reg | src_ev;
      end
   end
   assign irq_o = |(stat_reg & mask_reg);

   // ---------------- boot after reset ----------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         boot_hold_reg <= 1'b1;
      end else begin
         boot_hold_reg <= 1'b0;
      end
   end
   assign cpu_reset_o = boot_hold_reg;
   assign boot_addr_o = vic_pkg::BOOT_ADDR;

   // ---------------- AHB-Lite slave ----------------
   assign a8          = haddr_i[7:0];
   assign rd_go       = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
   assign wr_go       = hsel_i && htrans_i[1] && hready_i && hwrite_i;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata_reg;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= wr_go;
         wr_addr_reg <= a8;
      end
   end

   // read data is formed in the address phase and stands in the data phase
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_reg <= '0;
      end else if (rd_go) begin
         case (a8)
            vic_pkg::OFS_SRC_EN:   rdata_reg <= 32'(src_en_reg);
            vic_pkg::OFS_PEND:     rdata_reg <= 32'(pend_reg);
            vic_pkg::OFS_TMR_LO:   rdata_reg <= 32'(cnt_reg[vic_pkg::TMR_LO_W-1:0]);
            vic_pkg::OFS_TMR_HI:   rdata_reg <= 32'(hi_hold_reg);
            vic_pkg::OFS_SINK_IE:  rdata_reg <= 32'(sink_ie_reg);
            vic_pkg::OFS_SINK_POL: rdata_reg <= 32'(sink_pol_reg);
            vic_pkg::OFS_GPIO_IE:  rdata_reg <= gpio_ie_reg;
            vic_pkg::OFS_GPIO_POL: rdata_reg <= 32'(gpio_pol_reg);
            vic_pkg::OFS_STAT:     rdata_reg <= 32'(stat_reg);
            vic_pkg::OFS_MASK:     rdata_reg <= 32'(mask_reg);
            default:               rdata_reg <= 32'h00000000;
         endcase
      end
   end

   // upper bits frozen by the low read so a carry between reads is harmless
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         hi_hold_reg <= '0;
      end else if (rd_go && hit(a8, vic_pkg::OFS_TMR_LO)) begin
         hi_hold_reg <= cnt_reg[vic_pkg::TMR_W-1:vic_pkg::TMR_LO_W];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         src_en_reg   <= vic_pkg::RST_SRC_EN;
         sink_ie_reg  <= vic_pkg::RST_SINK_IE;
         sink_pol_reg <= vic_pkg::RST_SINK_POL;
         gpio_ie_reg  <= vic_pkg::RST_GPIO_IE;
         gpio_pol_reg <= vic_pkg::RST_GPIO_POL;
         mask_reg     <= vic_pkg::RST_MASK;
      end else if (wr_pend_reg) begin
         if (hit(wr_addr_reg, vic_pkg::OFS_SRC_EN)) begin
            src_en_reg <= hwdata_i[vic_pkg::NUM_SRC-1:0];
         end
         if (hit(wr_addr_reg, vic_pkg::OFS_SINK_IE)) begin
            sink_ie_reg <= hwdata_i[vic_pkg::SINK_W-1:0];
         end
         if (hit(wr_addr_reg, vic_pkg::OFS_SINK_POL)) begin
            sink_pol_reg <= hwdata_i[vic_pkg::SINK_W-1:0];
         end
         if (hit(wr_addr_reg, vic_pkg::OFS_GPIO_IE)) begin
            gpio_ie_reg <= hwdata_i;
         end
         if (hit(wr_addr_reg, vic_pkg::OFS_GPIO_POL)) begin
            gpio_pol_reg <= hwdata_i[vic_pkg::NUM_PORT-1:0];
         end
         if (hit(wr_addr_reg, vic_pkg::OFS_MASK)) begin
            mask_reg <= hwdata_i[vic_pkg::NUM_SRC-1:0];
         end
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   a_tick_period: assert property (tick |-> ##125 tick)
      else $error("tick period is not 125 cycles");

   a_timer_step: assert property (tick |=> cnt_reg == $past(cnt_reg) + 12'h001)
      else $error("timer did not advance by one on tick");

   a_t128_edge: assert property (src_ev[vic_pkg::SRC_T128]
      |=> cnt_reg[6] && !$past(cnt_reg[6]) && cnt_reg[5:0] == 6'h00)
      else $error("128 us event without bit 6 rising");

   a_t1024_edge: assert property ($rose(cnt_reg[9]) |-> $past(src_ev[vic_pkg::SRC_T1024]))
      else $error("bit 9 rose without 1024 us event");

   a_hi_latch: assert property (rd_go && a8 == vic_pkg::OFS_TMR_LO
      |=> hi_hold_reg == $past(cnt_reg[11:8]))
      else $error("upper timer bits not latched on low read");

   a_ep_pending: assert property (ep_event_i[0] && src_en_reg[vic_pkg::SRC_EP0]
      |=> pend_reg[vic_pkg::SRC_EP0])
      else $error("endpoint event not pending");

   a_sink_mask: assert property ((sink_edge & sink_ie_reg) != 8'h00
      && src_en_reg[vic_pkg::SRC_SINK] |=> pend_reg[vic_pkg::SRC_SINK])
      else $error("enabled sink edge lost");

   // a masked-off edge must not newly set the shared status bit
   a_gpio_mask: assert property ((gpio_edge & gpio_ie_reg) == 32'h00000000
      |=> !stat_reg[vic_pkg::SRC_GPIO] || $past(stat_reg[vic_pkg::SRC_GPIO]))
      else $error("general-purpose request ignores mask");

   a_sink_polarity: assert property (sink_edge != 8'h00
      |-> ((sink_edge & (sink_pin_i ^ ~sink_pol_reg)) == 8'h00))
      else $error("sink edge of wrong polarity");

   a_gpio_polarity: assert property (gpio_edge[0]
      |-> gpio_pin_i[0] == !gpio_pol_reg[0] && $past(gpio_pin_i[0]) == gpio_pol_reg[0])
      else $error("port 0 edge of wrong polarity");

   a_req_enabled: assert property (vec_req_o |-> src_en_reg[vec_num_o] && pend_reg[vec_num_o])
      else $error("request from disabled or idle source");

   a_req_held: assert property (vec_req_o && !vec_ack_i && $stable(src_en_reg)
      |=> pend_reg[$past(vec_num_o)])
      else $error("pending dropped before acceptance");

   // the core is held one cycle past release, then starts from address zero
   a_boot_zero: assert property ($fell(rst_i) |-> (cpu_reset_o && boot_addr_o == 14'h0000)
      ##1 !cpu_reset_o)
      else $error("boot hold not one cycle at address zero");

   c_vec_accept: cover property (vec_req_o && vec_ack_i);
   c_t1024_event: cover property (src_ev[vic_pkg::SRC_T1024]);
   c_gpio_event: cover property (src_ev[vic_pkg::SRC_GPIO]);
   c_timer_wrap: cover property (tick && cnt_reg == 12'hFFF);
endmodule
`default_nettype wire

/* File: include/vic_pkg.sv */
// constants for the vectored interrupt controller with free-running timer
package vic_pkg;
   localparam int unsigned NUM_SRC   = 11;
   localparam int unsigned VEC_W     = 4;
   localparam int unsigned SRC_T128  = 0;
   localparam int unsigned SRC_T1024 = 1;
   localparam int unsigned SRC_EP0   = 2;
   localparam int unsigned NUM_EP    = 5;
   localparam int unsigned SRC_HUB   = 7;
   localparam int unsigned SRC_SINK  = 8;
   localparam int unsigned SRC_GPIO  = 9;
   localparam int unsigned SRC_I2C   = 10;

   localparam int unsigned SINK_W    = 8;
   localparam int unsigned GPIO_W    = 32;
   localparam int unsigned NUM_PORT  = 4;
   localparam int unsigned PORT_W    = 8;

   localparam int unsigned TMR_W     = 12;
   localparam int unsigned TMR_LO_W  = 8;
   localparam int unsigned TMR_HI_W  = 4;
   localparam int unsigned TMR_BIT_A = 6;
   localparam int unsigned TMR_BIT_B = 9;
   localparam int unsigned CLK_PERIOD_NS  = 8;
   localparam int unsigned TICK_PERIOD_NS = 1000;
   localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned PRE_W          = 7;

   localparam int unsigned BOOT_W    = 14;
   localparam logic [BOOT_W-1:0] BOOT_ADDR = 14'h0000;

   localparam logic [7:0] OFS_SRC_EN   = 8'h00;
   localparam logic [7:0] OFS_PEND     = 8'h04;
   localparam logic [7:0] OFS_TMR_LO   = 8'h08;
   localparam logic [7:0] OFS_TMR_HI   = 8'h0C;
   localparam logic [7:0] OFS_SINK_IE  = 8'h10;
   localparam logic [7:0] OFS_SINK_POL = 8'h14;
   localparam logic [7:0] OFS_GPIO_IE  = 8'h18;
   localparam logic [7:0] OFS_GPIO_POL = 8'h1C;
   localparam logic [7:0] OFS_STAT     = 8'h20;
   localparam logic [7:0] OFS_MASK     = 8'h24;

   localparam logic [NUM_SRC-1:0]  RST_SRC_EN   = 11'h000;
   localparam logic [SINK_W-1:0]   RST_SINK_IE  = 8'h00;
   localparam logic [SINK_W-1:0]   RST_SINK_POL = 8'h00;
   localparam logic [GPIO_W-1:0]   RST_GPIO_IE  = 32'h00000000;
   localparam logic [NUM_PORT-1:0] RST_GPIO_POL = 4'h0;
   localparam logic [NUM_SRC-1:0]  RST_MASK     = 11'h000;
endpackage

/* File: tb/core_model.sv */
// behavioural processor core that accepts presented vectors
`timescale 1ns/1ps
`default_nettype none
module core_model (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   // vector link
   input  wire logic       vec_req_i,
   output logic            vec_ack_o,
   // acceptance control
   input  wire logic       accept_en_i,
   input  wire logic [3:0] delay_i
);
   logic [3:0] wait_reg;

   // a slow core lets the request stand delay_i + 1 cycles before ack; ack is one cycle only
   always_ff @(posedge mclk_i) begin
      if (rst_i || !vec_req_i || !accept_en_i || vec_ack_o) begin
         wait_reg  <= 4'h0;
         vec_ack_o <= 1'b0;
      end else if (wait_reg == delay_i) begin
         vec_ack_o <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* File: tb/vectored_interrupt_sources_timer_bench.sv */
// self-checking bench for the vectored interrupt controller and timer
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_sources_timer_bench;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic [31:0] hrdata_o;
   logic        hreadyout_o;
   logic        hresp_o;
   logic [4:0]  ep_event_i = 5'h00;
   logic        hub_event_i = 1'b0;
   logic        i2c_event_i = 1'b0;
   logic [7:0]  sink_pin_i = 8'h00;
   logic [31:0] gpio_pin_i = 32'h0;
   logic        vec_req_o;
   logic [3:0]  vec_num_o;
   logic        vec_ack_i;
   logic        irq_o;
   logic        cpu_reset_o;
   logic [13:0] boot_addr_o;
   logic        core_en = 1'b0;
   int          failures = 0;
   int          n_compared = 0;
   logic [31:0] r;
   logic [31:0] l1;
   logic [31:0] h1;
   logic [3:0]  got[$];

   localparam logic [7:0] RW_OFS [6] = '{vic_pkg::OFS_SRC_EN, vic_pkg::OFS_SINK_IE,
      vic_pkg::OFS_SINK_POL, vic_pkg::OFS_GPIO_IE, vic_pkg::OFS_GPIO_POL, vic_pkg::OFS_MASK};
   localparam logic [31:0] RW_MSK [6] = '{32'h7FF, 32'hFF, 32'hFF, 32'hFFFFFFFF, 32'hF, 32'h7FF};
   localparam logic [7:0]  P_SINK [6] = '{8'h02, 8'h03, 8'h02, 8'h82, 8'h02, 8'h82};
   localparam logic [31:0] P_GPIO [6] = '{32'h1, 32'h81, 32'h01000081, 32'h81,
      32'h01000081, 32'h01000081};
   localparam logic [31:0] P_EXP [6] = '{32'h0, 32'h300, 32'h0, 32'h200, 32'h100, 32'h0};

   always #4 mclk_i = ~mclk_i;

   vic_top u_vic_top (
      .mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hready_i(hreadyout_o),
      .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o), .ep_event_i(ep_event_i), .hub_event_i(hub_event_i),
      .i2c_event_i(i2c_event_i), .sink_pin_i(sink_pin_i), .gpio_pin_i(gpio_pin_i),
      .vec_req_o(vec_req_o), .vec_num_o(vec_num_o), .vec_ack_i(vec_ack_i),
      .irq_o(irq_o), .cpu_reset_o(cpu_reset_o), .boot_addr_o(boot_addr_o));

   core_model u_core_model (
      .mclk_i(mclk_i), .rst_i(rst_i), .vec_req_i(vec_req_o), .vec_ack_o(vec_ack_i),
      .accept_en_i(core_en), .delay_i(4'h2));

   // log of accepted vectors, taken where the core's ack is sampled
   always @(posedge mclk_i) begin
      if (vec_ack_i === 1'b1 && vec_req_o === 1'b1) begin
         got.push_back(vec_num_o);
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one single word transfer; read data lands in r
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      // no wait limit here: only the watchdog ends a stuck transfer
      do begin
         @(posedge mclk_i);
      end while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do begin
         @(posedge mclk_i);
      end while (hreadyout_o !== 1'b1);
      r = hrdata_o;
   endtask

   task automatic final_report;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge mclk_i);
      failures++;
      final_report;
   end

   initial begin
      repeat (10) @(posedge mclk_i);
      chk("cpu_reset held", {31'h0, cpu_reset_o}, 32'h1);
      rst_i <= 1'b0;
      chk("boot address", {18'h0, boot_addr_o}, 32'h0);
      bus(1'b0, vic_pkg::OFS_PEND, 32'h0);
      chk("pending at reset", r, 32'h0);
      chk("cpu_reset released", {31'h0, cpu_reset_o}, 32'h0);
      chk("bus response", {31'h0, hresp_o}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, RW_OFS[i], 32'h0);
         chk("reset value", r, 32'h0);
         bus(1'b1, RW_OFS[i], 32'hFFFFFFFF);
         bus(1'b0, RW_OFS[i], 32'h0);
         chk("write readback", r, RW_MSK[i]);
         bus(1'b1, RW_OFS[i], 32'h0);
      end
      bus(1'b1, 8'h30, 32'hFFFFFFFF);
      bus(1'b0, 8'h30, 32'h0);
      chk("unmapped read", r, 32'h0);
      // 32000 cycles between the two low reads is exactly 256 ticks
      bus(1'b0, vic_pkg::OFS_TMR_LO, 32'h0);
      l1 = r;
      bus(1'b0, vic_pkg::OFS_TMR_HI, 32'h0);
      h1 = r;
      repeat (31996) @(posedge mclk_i);
      bus(1'b0, vic_pkg::OFS_TMR_LO, 32'h0);
      chk("timer low", r, l1);
      repeat (32000) @(posedge mclk_i);
      bus(1'b0, vic_pkg::OFS_TMR_HI, 32'h0);
      chk("timer high latched", r, (h1 + 32'h1) & 32'hF);
      repeat (200) @(posedge mclk_i);
      bus(1'b0, vic_pkg::OFS_STAT, 32'h0);
      chk("timer events", r, 32'h3);
      bus(1'b0, vic_pkg::OFS_STAT, 32'h0);
      chk("status read clear", r, 32'h0);
      for (int m = 1; m >= 0; m--) begin
         bus(1'b1, vic_pkg::OFS_MASK, (m == 1) ? 32'h80 : 32'h0);
         hub_event_i <= 1'b1;
         @(posedge mclk_i);
         hub_event_i <= 1'b0;
         repeat (2) @(posedge mclk_i);
         chk("irq level", {31'h0, irq_o}, m);
         bus(1'b0, vic_pkg::OFS_STAT, 32'h0);
         chk("hub status", r & 32'h80, 32'h80);
         chk("irq after read", {31'h0, irq_o}, 32'h0);
      end
      bus(1'b1, vic_pkg::OFS_SINK_IE, 32'h81);
      bus(1'b1, vic_pkg::OFS_SINK_POL, 32'h80);
      bus(1'b1, vic_pkg::OFS_GPIO_IE, 32'h01000080);
      bus(1'b1, vic_pkg::OFS_GPIO_POL, 32'h8);
      for (int i = 0; i < 6; i++) begin
         sink_pin_i <= P_SINK[i];
         gpio_pin_i <= P_GPIO[i];
         repeat (3) @(posedge mclk_i);
         bus(1'b0, vic_pkg::OFS_STAT, 32'h0);
         chk("pin status", r & 32'h300, P_EXP[i]);
      end
      bus(1'b1, vic_pkg::OFS_SRC_EN, 32'h7FC);
      ep_event_i <= 5'h1F;
      hub_event_i <= 1'b1;
      i2c_event_i <= 1'b1;
      sink_pin_i <= 8'h02;
      gpio_pin_i <= 32'h81;
      @(posedge mclk_i);
      ep_event_i <= 5'h00;
      hub_event_i <= 1'b0;
      i2c_event_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      bus(1'b0, vic_pkg::OFS_PEND, 32'h0);
      chk("pending set", r, 32'h7FC);
      chk("first vector", {27'h0, vec_req_o, vec_num_o}, 32'h12);
      // a disabled source hides its vector but keeps its pending bit
      bus(1'b1, vic_pkg::OFS_SRC_EN, 32'h7F8);
      bus(1'b0, vic_pkg::OFS_PEND, 32'h0);
      chk("pending kept", r, 32'h7FC);
      // the withdrawn vector leaves one idle cycle before the next is presented
      @(posedge mclk_i);
      chk("vector skip", {27'h0, vec_req_o, vec_num_o}, 32'h13);
      bus(1'b1, vic_pkg::OFS_SRC_EN, 32'h7FC);
      core_en <= 1'b1;
      for (int n = 0; n < 500 && got.size() < 9; n++) @(posedge mclk_i);
      chk("vector count", got.size(), 32'h9);
      // vector 3 already stands when 2 is enabled again, so 3 is taken first
      for (int i = 0; i < 9 && i < got.size(); i++) begin
         chk("vector order", {28'h0, got[i]}, (i < 2) ? 3 - i : i + 2);
      end
      bus(1'b0, vic_pkg::OFS_PEND, 32'h0);
      chk("pending drained", r, 32'h0);
      chk("request idle", {31'h0, vec_req_o}, 32'h0);
      final_report;
   end
endmodule
`default_nettype wire
